// File: src/cnc_plc_params.svh
// Contract
// - Axis count shown binary on four bits.
// - Moving flag follows each axis start and stop.
// - Direction bit one forward, zero reverse.
// - Direction bit holds last value when stopped.
// - Servo ready output follows servo readiness.
// - Emergency stop low resets and halts motion.
// - Automatic overtravel decelerates axis, alarms, interrupts.
// - Manual overtravel decelerates only moving axes.
// - Overtravel direction locked until alarm cleared.
// - Alarm output high during any alarm.
// - Reset clearing alarm returns alarm output low.
// - Code zero gives manual data input confirmation.
// - Code one, no trial-cut gives memory run.
// - Code one with trial-cut gives trial-cut mode.
// - Code three gives program edit confirmation.
// - Code four, no step gives handwheel.
// - Code four with step gives step feed.
// - Code five, no return gives jog.
// - Code five, return, no zero gives reference return.
// - Code five, return, zero gives program zero; the code decodes it but sets no confirmation bit.
`ifndef CNC_PLC_PARAMS_SVH
`define CNC_PLC_PARAMS_SVH
`define OFS_AXIS_COUNT 4'h0
`define OFS_MOTION 4'h1
`define OFS_DIRECTION 4'h2
`define OFS_LIMIT_PLUS 4'h3
`define OFS_LIMIT_MINUS 4'h4
`define OFS_ALARM 4'h5
`define OFS_MODE_SELECT 4'h6
`define OFS_CONFIRM_MAIN 4'h7
`define OFS_CONFIRM_REFRET 4'h8
`define OFS_CONFIRM_TRIAL 4'h9
`define OFS_SERVO_STATUS 4'hA
`define BIT_STEP_SELECT 3
`define BIT_TRIAL_SELECT 4
`define BIT_ZERO_SELECT 6
`define BIT_REFRET_SELECT 7
`define BIT_CONF_STEP 0
`define BIT_CONF_HANDWHEEL 1
`define BIT_CONF_JOG 2
`define BIT_CONF_MDI 3
`define BIT_CONF_MEMORY 5
`define BIT_CONF_EDIT 6
`define BIT_CONF_REFRET 5
`define BIT_CONF_TRIAL 3
`define BIT_SERVO_READY 6
`define BIT_ALARM 0
`define CODE_MDI 3'h0
`define CODE_MEMORY 3'h1
`define CODE_EDIT 3'h3
`define CODE_HANDWHEEL 3'h4
`define CODE_JOG 3'h5
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h00000000
`define DEFAULT_AXES 4'h5
`endif

// File: src/cnc_plc_pkg.sv
package cnc_plc_pkg;
  localparam int NAXES = 5;

  typedef enum logic [9:0] {
    MODE_NONE = 10'b0000000001,
    MODE_MDI = 10'b0000000010,
    MODE_MEMORY = 10'b0000000100,
    MODE_TRIAL = 10'b0000001000,
    MODE_EDIT = 10'b0000010000,
    MODE_HANDWHEEL = 10'b0000100000,
    MODE_STEP = 10'b0001000000,
    MODE_JOG = 10'b0010000000,
    MODE_REFRET = 10'b0100000000,
    MODE_PROGZERO = 10'b1000000000
  } mode_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [NAXES-1:0] moving;
    logic [NAXES-1:0] forward;
  } axis_motion_t;

  typedef struct packed {
    logic [NAXES-1:0] decel;
    logic [NAXES-1:0] lockForward;
    logic [NAXES-1:0] lockReverse;
  } axis_guard_t;

  typedef struct packed {
    logic [7:0] main;
    logic [7:0] refret;
    logic [7:0] trial;
  } mode_confirm_t;
endpackage

// File: src/cnc_plc_status_mode_interface.sv
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "cnc_plc_params.svh"
module cnc_plc_status_mode_interface #(
  parameter logic [3:0] CTRL_AXES = `DEFAULT_AXES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cnc_plc_pkg::avmm_req_t avReq,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  input wire cnc_plc_pkg::axis_motion_t axisMotion,
  input wire logic servoReadyIn,
  input wire logic programAlarmIn,
  input wire logic servoAlarmIn,
  input wire logic resetKeyIn,
  input wire logic estop_n,
  output cnc_plc_pkg::axis_guard_t axisGuard,
  output logic haltAll,
  output logic programInterrupt,
  output logic controllerReset,
  output logic autoOperation,
  output logic servo_ready_out,
  output logic alarm_out_bit,
  output logic [3:0] axis_count_bits,
  output logic [cnc_plc_pkg::NAXES-1:0] axis_moving_flag,
  output logic [cnc_plc_pkg::NAXES-1:0] axis_direction_bit,
  output cnc_plc_pkg::mode_confirm_t modeConfirm
);
  import cnc_plc_pkg::*;

  logic [7:0] limitPlus_r;
  logic [7:0] limitMinus_r;
  logic [7:0] modeSelect_r;
  logic [NAXES-1:0] moving_r;
  logic [NAXES-1:0] direction_r;
  logic [NAXES-1:0] otPrev_r;
  logic [NAXES-1:0] lockFwd_r;
  logic [NAXES-1:0] lockRev_r;
  logic [NAXES-1:0] decel_r;
  logic [NAXES-1:0] otActive;
  logic [NAXES-1:0] otRise;
  logic [NAXES-1:0] motionDir;
  logic estopMeta_r;
  logic estopSync_r;
  logic estopPrev_r;
  logic alarm_r;
  logic servoReady_r;
  logic interrupt_r;
  logic ctrlReset_r;
  logic auto_r;
  logic halt_r;
  logic [3:0] axisCount_r;
  logic waitReq_r;
  logic [31:0] readData_r;
  logic [31:0] readNxt;
  mode_t modeNxt;
  mode_confirm_t confirm_r;
  mode_confirm_t confirmNxt;
  logic estopFall;
  logic alarmClear;
  logic alarmSet;
  logic autoNxt;
  logic writeTake;
  logic readTake;

  // A request is answered in the cycle after it is seen.
  // Waitrequest falls for one cycle per request, so each access takes two cycles.
  assign readTake = avReq.read && waitReq_r;
  assign writeTake = avReq.write && !waitReq_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
    end else if ((avReq.read || avReq.write) && waitReq_r) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  // Unmapped offsets and unused bit positions read as zero.
  always_comb begin
    readNxt = `RESET_WORD;
    if (avReq.address == `OFS_AXIS_COUNT) begin
      readNxt[3:0] = axisCount_r;
    end else if (avReq.address == `OFS_MOTION) begin
      readNxt[NAXES-1:0] = moving_r;
    end else if (avReq.address == `OFS_DIRECTION) begin
      readNxt[NAXES-1:0] = direction_r;
    end else if (avReq.address == `OFS_LIMIT_PLUS) begin
      readNxt[7:0] = limitPlus_r;
    end else if (avReq.address == `OFS_LIMIT_MINUS) begin
      readNxt[7:0] = limitMinus_r;
    end else if (avReq.address == `OFS_ALARM) begin
      readNxt[`BIT_ALARM] = alarm_r;
    end else if (avReq.address == `OFS_MODE_SELECT) begin
      readNxt[7:0] = modeSelect_r;
    end else if (avReq.address == `OFS_CONFIRM_MAIN) begin
      readNxt[7:0] = confirm_r.main;
    end else if (avReq.address == `OFS_CONFIRM_REFRET) begin
      readNxt[7:0] = confirm_r.refret;
    end else if (avReq.address == `OFS_CONFIRM_TRIAL) begin
      readNxt[7:0] = confirm_r.trial;
    end else if (avReq.address == `OFS_SERVO_STATUS) begin
      readNxt[`BIT_SERVO_READY] = servoReady_r;
    end
  end

  // Read data stands from the answer cycle until the next read.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readData_r <= `RESET_WORD;
    end else if (readTake) begin
      readData_r <= readNxt;
    end
  end

  // Only the input bytes are writable; all other offsets ignore writes.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      limitPlus_r <= `RESET_BYTE;
      limitMinus_r <= `RESET_BYTE;
      modeSelect_r <= `RESET_BYTE;
    end else if (writeTake && avReq.byteenable[0]) begin
      if (avReq.address == `OFS_LIMIT_PLUS) begin
        limitPlus_r <= avReq.writedata[7:0];
      end else if (avReq.address == `OFS_LIMIT_MINUS) begin
        limitMinus_r <= avReq.writedata[7:0];
      end else if (avReq.address == `OFS_MODE_SELECT) begin
        modeSelect_r <= avReq.writedata[7:0];
      end
    end
  end

  // The axis count is a fixed build option, reloaded after every reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      axisCount_r <= 4'h0;
    end else begin
      axisCount_r <= CTRL_AXES;
    end
  end

  // Servo ready is the input registered once; braking does not depend on it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      servoReady_r <= 1'b0;
    end else begin
      servoReady_r <= servoReadyIn;
    end
  end

  // The emergency stop pin is asynchronous to the core clock.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      estopMeta_r <= 1'b1;
      estopSync_r <= 1'b1;
      estopPrev_r <= 1'b1;
    end else begin
      estopMeta_r <= estop_n;
      estopSync_r <= estopMeta_r;
      estopPrev_r <= estopSync_r;
    end
  end

  // One-cycle pulse on the first synchronised low of the emergency stop.
  assign estopFall = estopPrev_r && !estopSync_r;

  // A falling emergency stop resets once; the halt holds while the pin stays low.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrlReset_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      ctrlReset_r <= estopFall || resetKeyIn;
      halt_r <= !estopSync_r;
    end
  end

  // Select bits that do not belong to the decoded code are ignored.
  always_comb begin
    modeNxt = MODE_NONE;
    case (modeSelect_r[2:0])
      `CODE_MDI: begin
        modeNxt = MODE_MDI;
      end
      `CODE_MEMORY: begin
        if (modeSelect_r[`BIT_TRIAL_SELECT]) begin
          modeNxt = MODE_TRIAL;
        end else begin
          modeNxt = MODE_MEMORY;
        end
      end
      `CODE_EDIT: begin
        modeNxt = MODE_EDIT;
      end
      `CODE_HANDWHEEL: begin
        if (modeSelect_r[`BIT_STEP_SELECT]) begin
          modeNxt = MODE_STEP;
        end else begin
          modeNxt = MODE_HANDWHEEL;
        end
      end
      `CODE_JOG: begin
        if (!modeSelect_r[`BIT_REFRET_SELECT]) begin
          modeNxt = MODE_JOG;
        end else if (!modeSelect_r[`BIT_ZERO_SELECT]) begin
          modeNxt = MODE_REFRET;
        end else begin
          modeNxt = MODE_PROGZERO;
        end
      end
      default: begin
        modeNxt = MODE_NONE;
      end
    endcase
  end

  // Each mode drives at most one confirmation bit, so they never overlap.
  always_comb begin
    confirmNxt = '0;
    autoNxt = 1'b0;
    case (modeNxt)
      MODE_MDI: begin
        confirmNxt.main[`BIT_CONF_MDI] = 1'b1;
        autoNxt = 1'b1;
      end
      MODE_MEMORY: begin
        confirmNxt.main[`BIT_CONF_MEMORY] = 1'b1;
        autoNxt = 1'b1;
      end
      MODE_TRIAL: begin
        confirmNxt.trial[`BIT_CONF_TRIAL] = 1'b1;
        autoNxt = 1'b1;
      end
      MODE_EDIT: begin
        confirmNxt.main[`BIT_CONF_EDIT] = 1'b1;
        autoNxt = 1'b1;
      end
      MODE_HANDWHEEL: begin
        confirmNxt.main[`BIT_CONF_HANDWHEEL] = 1'b1;
      end
      MODE_STEP: begin
        confirmNxt.main[`BIT_CONF_STEP] = 1'b1;
      end
      MODE_JOG: begin
        confirmNxt.main[`BIT_CONF_JOG] = 1'b1;
      end
      MODE_REFRET: begin
        confirmNxt.refret[`BIT_CONF_REFRET] = 1'b1;
      end
      default: begin
        confirmNxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      confirm_r <= '0;
    end else begin
      confirm_r <= confirmNxt;
    end
  end

  // Edit is grouped with the automatic modes, so overtravel there interrupts the program.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      auto_r <= 1'b0;
    end else begin
      auto_r <= autoNxt;
    end
  end

  // Motion flags follow the axis logic; direction freezes while stopped.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      moving_r <= '0;
    end else begin
      moving_r <= axisMotion.moving;
    end
  end

  // Per-axis overtravel edge detection, braking and direction locks.
  genvar g;
  generate
    for (g = 0; g < NAXES; g++) begin : g_axis
      assign otActive[g] = limitPlus_r[g] || limitMinus_r[g];
      assign otRise[g] = otActive[g] && !otPrev_r[g];
      assign motionDir[g] = axisMotion.moving[g] ? axisMotion.forward[g] : direction_r[g];

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          direction_r[g] <= 1'b0;
        end else if (axisMotion.moving[g]) begin
          direction_r[g] <= axisMotion.forward[g];
        end else begin
          direction_r[g] <= direction_r[g];
        end
      end

      // The limit registers reset inactive, so no false overtravel edge follows reset.
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          otPrev_r[g] <= 1'b0;
        end else begin
          otPrev_r[g] <= otActive[g];
        end
      end

      // In automatic modes every overtravelled axis brakes; in manual ones only a moving one.
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          decel_r[g] <= 1'b0;
        end else if (auto_r) begin
          decel_r[g] <= otActive[g];
        end else begin
          decel_r[g] <= otActive[g] && axisMotion.moving[g];
        end
      end

      // The lock set wins over a clear arriving in the same cycle.
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          lockFwd_r[g] <= 1'b0;
          lockRev_r[g] <= 1'b0;
        end else if (otRise[g]) begin
          lockFwd_r[g] <= lockFwd_r[g] || motionDir[g];
          lockRev_r[g] <= lockRev_r[g] || !motionDir[g];
        end else if (alarmClear) begin
          lockFwd_r[g] <= 1'b0;
          lockRev_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // A set source wins over a clear that lands in the same cycle.
  assign alarmSet = (|otRise) || programAlarmIn || servoAlarmIn;
  assign alarmClear = ctrlReset_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarm_r <= 1'b0;
    end else if (alarmSet) begin
      alarm_r <= 1'b1;
    end else if (alarmClear) begin
      alarm_r <= 1'b0;
    end
  end

  // Program execution is interrupted only for overtravel in an automatic mode.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      interrupt_r <= 1'b0;
    end else begin
      interrupt_r <= auto_r && (|otRise);
    end
  end

  // Every output below is a plain copy of a register.
  assign avReaddata = readData_r;
  assign avWaitrequest = waitReq_r;
  assign axisGuard.decel = decel_r;
  assign axisGuard.lockForward = lockFwd_r;
  assign axisGuard.lockReverse = lockRev_r;
  assign haltAll = halt_r;
  assign programInterrupt = interrupt_r;
  assign controllerReset = ctrlReset_r;
  assign autoOperation = auto_r;
  assign servo_ready_out = servoReady_r;
  assign alarm_out_bit = alarm_r;
  assign axis_count_bits = axisCount_r;
  assign axis_moving_flag = moving_r;
  assign axis_direction_bit = direction_r;
  assign modeConfirm = confirm_r;
endmodule // cnc_plc_status_mode_interface

// File: verification/cnc_plc_status_mode_interface_sva.sv
`timescale 1ns/100ps
module cnc_plc_checker #(
  parameter logic [3:0] CTRL_AXES = 4'h5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] avReaddata,
  input wire logic avWaitrequest,
  input wire cnc_plc_pkg::axis_motion_t axisMotion,
  input wire logic servoReadyIn,
  input wire logic programAlarmIn,
  input wire logic servoAlarmIn,
  input wire logic resetKeyIn,
  input wire logic estop_n,
  input wire logic haltAll,
  input wire logic controllerReset,
  input wire logic servo_ready_out,
  input wire logic alarm_out_bit,
  input wire logic [3:0] axis_count_bits,
  input wire logic [cnc_plc_pkg::NAXES-1:0] axis_moving_flag,
  input wire logic [cnc_plc_pkg::NAXES-1:0] axis_direction_bit,
  input wire cnc_plc_pkg::mode_confirm_t modeConfirm
);
  import cnc_plc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  count_value_a: assert property ($past(rst_n) |-> axis_count_bits == CTRL_AXES)
    else $error("axis count output wrong");
  moving_follow_a: assert property ($past(rst_n) |-> axis_moving_flag == $past(axisMotion.moving))
    else $error("moving flags do not follow motion");
  dir_forward_a: assert property ($past(rst_n) |->
    ((axis_direction_bit ^ $past(axisMotion.forward)) & $past(axisMotion.moving)) == '0)
    else $error("direction bit wrong while moving");
  dir_hold_a: assert property ($past(rst_n) |->
    ((axis_direction_bit ^ $past(axis_direction_bit)) & ~$past(axisMotion.moving)) == '0)
    else $error("direction bit changed while stopped");
  servo_follow_a: assert property ($past(rst_n) |-> servo_ready_out == $past(servoReadyIn))
    else $error("servo ready output wrong");
  estop_halt_a: assert property (!estop_n [*3] |=> haltAll)
    else $error("no halt after emergency stop");
  alarm_set_a: assert property (programAlarmIn || servoAlarmIn |=> alarm_out_bit)
    else $error("alarm output not raised");
  alarm_clear_a: assert property (controllerReset && !programAlarmIn && !servoAlarmIn
    |=> !alarm_out_bit) else $error("alarm not cleared by reset");
  reset_pulse_a: assert property (resetKeyIn |=> controllerReset)
    else $error("reset key did not reset controller");
  confirm_excl_a: assert property ($onehot0(modeConfirm))
    else $error("mode confirmations not exclusive");
  wait_single_a: assert property (!avWaitrequest |=> avWaitrequest)
    else $error("waitrequest low too long");
  read_upper_a: assert property (!avWaitrequest |-> avReaddata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule // cnc_plc_checker

bind cnc_plc_status_mode_interface cnc_plc_checker #(.CTRL_AXES(CTRL_AXES)) u_chk (
  .core_clk, .rst_n, .avReaddata, .avWaitrequest, .axisMotion, .servoReadyIn,
  .programAlarmIn, .servoAlarmIn, .resetKeyIn, .estop_n, .haltAll, .controllerReset,
  .servo_ready_out, .alarm_out_bit, .axis_count_bits, .axis_moving_flag,
  .axis_direction_bit, .modeConfirm);

// File: verification/axis_motion_model.sv
`timescale 1ns/100ps
module axis_motion_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [cnc_plc_pkg::NAXES-1:0] wantMove,
  input wire logic [cnc_plc_pkg::NAXES-1:0] wantFwd,
  input wire cnc_plc_pkg::axis_guard_t axisGuard,
  output cnc_plc_pkg::axis_motion_t axisMotion
);
  import cnc_plc_pkg::*;
  logic [NAXES-1:0] blocked;
  // A decelerating axis or one asked to move in a locked direction stays still.
  assign blocked = axisGuard.decel | (wantFwd & axisGuard.lockForward) |
    (~wantFwd & axisGuard.lockReverse);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      axisMotion <= '0;
    end else begin
      axisMotion.moving <= wantMove & ~blocked;
      axisMotion.forward <= wantFwd;
    end
  end
endmodule // axis_motion_model

// File: verification/cnc_plc_status_mode_interface_tb.sv
`timescale 1ns/100ps
module cnc_plc_status_mode_interface_tb;
  import cnc_plc_pkg::*;
  logic core_clk, rst_n, servoReadyIn, programAlarmIn, servoAlarmIn, resetKeyIn, estop_n;
  logic avWaitrequest, haltAll, programInterrupt, controllerReset, autoOperation;
  logic servo_ready_out, alarm_out_bit;
  logic [3:0] axis_count_bits;
  logic [4:0] axis_moving_flag, axis_direction_bit, wantMove, wantFwd;
  logic [31:0] avReaddata, rdData;
  avmm_req_t avReq;
  axis_motion_t axisMotion;
  axis_guard_t axisGuard;
  mode_confirm_t modeConfirm;
  int error_cnt = 0;
  int num_checks = 0;
  int irqCnt = 0;
  logic [7:0] modeSel [12] = '{8'hD8, 8'h01, 8'h11, 8'hFB, 8'h04, 8'h0C, 8'h05, 8'h85,
    8'hC5, 8'h02, 8'h06, 8'h07};
  logic [23:0] modeExp [12] = '{24'h080000, 24'h200000, 24'h000008, 24'h400000,
    24'h020000, 24'h010000, 24'h040000, 24'h002000, 24'h0, 24'h0, 24'h0, 24'h0};

  cnc_plc_status_mode_interface #(.CTRL_AXES(4'h5)) u_dut (
    .core_clk, .rst_n, .avReq, .avReaddata, .avWaitrequest, .axisMotion, .servoReadyIn,
    .programAlarmIn, .servoAlarmIn, .resetKeyIn, .estop_n, .axisGuard, .haltAll,
    .programInterrupt, .controllerReset, .autoOperation, .servo_ready_out, .alarm_out_bit,
    .axis_count_bits, .axis_moving_flag, .axis_direction_bit, .modeConfirm);
  axis_motion_model u_motion (.core_clk, .rst_n, .wantMove, .wantFwd, .axisGuard, .axisMotion);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (programInterrupt === 1'h1) irqCnt++;

  task automatic complete_run;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    num_checks++;
    if (got !== expv) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
    @(posedge core_clk);
    avReq <= '{read: !wr, write: wr, address: addr, writedata: wdata, byteenable: 4'hF};
    do begin
      @(posedge core_clk);
    end while (avWaitrequest !== 1'h0);
    rdData = avReaddata;
    avReq <= '0;
  endtask
  task automatic rd(input logic [3:0] addr, input logic [31:0] expv, input string what);
    bus(1'h0, addr, 32'h0);
    chk(what, expv, rdData);
  endtask
  task automatic pressReset;
    @(posedge core_clk);
    resetKeyIn <= 1'h1;
    @(posedge core_clk);
    resetKeyIn <= 1'h0;
    tick(3);
  endtask
  task automatic drive(input logic [4:0] mv, input logic [4:0] fw);
    @(posedge core_clk);
    wantMove <= mv;
    wantFwd <= fw;
    tick(3);
  endtask

  initial begin
    #50000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rst_n = 1'h0;
    avReq = '0;
    {wantMove, wantFwd, servoReadyIn, programAlarmIn, servoAlarmIn, resetKeyIn} = '0;
    estop_n = 1'h1;
    tick(12);
    rst_n <= 1'h1;
    rd(4'h0, 32'h5, "axis count");
    rd(4'h5, 32'h0, "alarm after reset");
    rd(4'hF, 32'h0, "unmapped read");
    bus(1'h1, 4'h0, 32'hA);
    rd(4'h0, 32'h5, "axis count after write");
    for (int i = 0; i < 12; i++) begin
      bus(1'h1, 4'h6, {24'h0, modeSel[i]});
      tick(3);
      chk("mode confirm", {8'h0, modeExp[i]}, {8'h0, modeConfirm});
      rd(4'h7, {24'h0, modeExp[i][23:16]}, "main confirm");
      rd(4'h6, {24'h0, modeSel[i]}, "mode select");
    end
    drive(5'h01, 5'h01);
    rd(4'h1, 32'h01, "moving forward");
    rd(4'h2, 32'h01, "direction forward");
    drive(5'h00, 5'h00);
    chk("moving stopped", 32'h0, 32'(axis_moving_flag));
    chk("direction held", 32'h1, 32'(axis_direction_bit));
    drive(5'h01, 5'h00);
    chk("direction reverse", 32'h0, 32'(axis_direction_bit));
    drive(5'h00, 5'h01);
    chk("reverse held", 32'h0, 32'(axis_direction_bit));
    servoReadyIn <= 1'h1;
    rd(4'hA, 32'h40, "servo status");
    chk("servo port", 32'h1, 32'(servo_ready_out));
    bus(1'h1, 4'h6, 32'h01);
    drive(5'h02, 5'h02);
    chk("auto operation", 32'h1, 32'(autoOperation));
    bus(1'h1, 4'h3, 32'h02);
    tick(4);
    chk("auto alarm", 32'h1, 32'(alarm_out_bit));
    chk("auto decel", 32'h02, 32'(axisGuard.decel));
    chk("auto stop", 32'h0, 32'(axis_moving_flag));
    chk("interrupt count", 32'h1, 32'(irqCnt));
    bus(1'h1, 4'h3, 32'h00);
    tick(3);
    chk("forward lock", 32'h02, 32'(axisGuard.lockForward));
    chk("locked stays", 32'h0, 32'(axis_moving_flag));
    drive(5'h02, 5'h00);
    chk("reverse allowed", 32'h02, 32'(axis_moving_flag));
    drive(5'h00, 5'h00);
    pressReset();
    chk("alarm cleared", 32'h0, 32'(alarm_out_bit));
    chk("lock cleared", 32'h0, 32'(axisGuard.lockForward));
    bus(1'h1, 4'h6, 32'h05);
    drive(5'h08, 5'h00);
    chk("manual operation", 32'h0, 32'(autoOperation));
    bus(1'h1, 4'h4, 32'h0C);
    tick(3);
    chk("manual decel", 32'h08, 32'(axisGuard.decel));
    chk("reverse lock", 32'h0C, 32'(axisGuard.lockReverse));
    chk("manual alarm", 32'h1, 32'(alarm_out_bit));
    chk("no manual interrupt", 32'h1, 32'(irqCnt));
    bus(1'h1, 4'h4, 32'h00);
    drive(5'h04, 5'h04);
    chk("opposite move", 32'h04, 32'(axis_moving_flag));
    drive(5'h00, 5'h00);
    estop_n <= 1'h0;
    tick(5);
    chk("halt", 32'h1, 32'(haltAll));
    chk("estop clears alarm", 32'h0, 32'(alarm_out_bit));
    estop_n <= 1'h1;
    tick(5);
    chk("halt released", 32'h0, 32'(haltAll));
    programAlarmIn <= 1'h1;
    tick(1);
    programAlarmIn <= 1'h0;
    rd(4'h5, 32'h1, "program alarm");
    pressReset();
    rd(4'h5, 32'h0, "program alarm cleared");
    servoAlarmIn <= 1'h1;
    tick(1);
    servoAlarmIn <= 1'h0;
    tick(2);
    chk("servo alarm", 32'h1, 32'(alarm_out_bit));
    complete_run();
  end
endmodule // cnc_plc_status_mode_interface_tb
